/* File: smrt_tx.sv */
// Serial measurement report sender with APB registers
`timescale 1ns/1ps
`include "smrt_regs.svh"

module smrt_tx #(
    parameter logic [31:0] P_SCAN_RST = `SMRT_SCAN_RST
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    input wire logic [3:0] i_type_code_bit_weight8,
    input wire logic [3:0] i_type_code_bit_weight4,
    input wire logic [3:0] i_type_code_bit_weight2,
    input wire logic [3:0] i_type_code_bit_weight1,
    output logic [3:0] o_range_sel,
    input wire logic i_rx,
    output logic o_tx,
    output logic o_irq
);
    import smrt_pkg::*;

    smrt_state_s q;
    smrt_state_s d;

    // ==========================================================
    // Text tables
    localparam logic [47:0] S_CONDUCTIVITY_FIELD_NAME = 48'h0000_434F_4E44;
    localparam logic [47:0] S_HI = 48'h0048_4941_4C4D;
    localparam logic [47:0] S_NOC = 48'h004E_4F43_414C;

    // (R14) Names per type code
    function automatic logic [47:0] name_of(input logic [3:0] c);
        case (c)
            4'd1: name_of = S_CONDUCTIVITY_FIELD_NAME;
            4'd2: name_of = "Na";
            4'd3: name_of = "pH";
            4'd4: name_of = "ORP";
            4'd5: name_of = "DO";
            4'd6: name_of = "ACID";
            default: name_of = "VAL";
        endcase
    endfunction

    // (R11) Units per type code
    function automatic logic [47:0] unit_of(input logic [3:0] c);
        case (c)
            4'd1: unit_of = "uS";
            4'd2: unit_of = "ppB";
            4'd3: unit_of = "pH";
            4'd4: unit_of = "mV";
            4'd5: unit_of = "ppm";
            4'd6: unit_of = "Pct";
            default: unit_of = "cnt";
        endcase
    endfunction

    // Strings right-aligned, zero-padded
    function automatic logic [3:0] str_len(input logic [47:0] s);
        str_len = 4'd0;
        for (int i = 0; i < 6; i++) begin
            str_len = str_len + {3'd0, s[8*i +: 8] != 8'h00};
        end
    endfunction

    // (R5) Digits above nine are clamped so nothing unprintable leaves
    function automatic logic [7:0] asc(input logic [3:0] n);
        asc = (n > 4'd9) ? 8'h39 : (8'h30 | {4'h0, n});
    endfunction

    // (R10) Five digits with a period after dp digits (dp 0: none)
    function automatic logic [7:0] num_char(input logic [22:0] v, input logic [3:0] i);
        logic [2:0] dp;
        logic [3:0] j;
        dp = v[22:20];
        j = (dp != 3'd0 && i > {1'b0, dp}) ? i - 4'd1 : i;
        num_char = (dp != 3'd0 && i == {1'b0, dp}) ? 8'h2E : asc(v[4*(4 - j[2:0]) +: 4]);
    endfunction

    // Date mm-dd-yyyy (base 7) and time hh:mm:ss (base 5)
    function automatic logic [7:0] dt_char(input logic [31:0] v, input logic [3:0] base,
                                           input logic [7:0] sepc, input logic [3:0] i);
        logic [3:0] n;
        n = base - i + {3'd0, i > 4'd2} + {3'd0, i > 4'd5};
        dt_char = (i == 4'd2 || i == 4'd5) ? sepc : asc(v[4*n[2:0] +: 4]);
    endfunction

    // ==========================================================
    // Token decode
    smrt_kind_e kind;
    logic [47:0] str;
    logic [22:0] num;
    logic [3:0] len;
    logic [7:0] chr;
    logic [3:0] code;
    logic cal;
    logic has_temp;
    logic [10:0] keep;

    always_comb begin
        code = q.code[4*q.ch[1:0] +: 4];
        cal = q.ch_st[q.ch[1:0]][`SMRT_CHST_CAL];
        has_temp = (code == 4'd1) || (code == 4'd2) || (code == 4'd3);
        // (R13) Uncalibrated: only ID and marker
        // (R14) Temperature and raw fields by type; bit k gates token k+1
        keep = cal ? {1'b0, q.ch_st[q.ch[1:0]][2:1] != 2'b00, {3{code == 4'd1}}, {3{has_temp}}, 3'h7} : 11'h400;
        kind = SMRT_K_STR;
        str = 48'h0;
        num = q.ch_val[q.ch[1:0]];
        if (q.ch == 3'd4) begin
            // (R7) Stamp message closes the packet
            case (q.tk)
                4'd0: kind = SMRT_K_ID;
                4'd1: str = "DATE";
                4'd2: kind = SMRT_K_DATE;
                4'd3: str = "TIME";
                4'd4: kind = SMRT_K_TIME;
                `SMRT_LAST_TK: kind = SMRT_K_CR;
                default: kind = SMRT_K_NONE;
            endcase
        end else begin
            case (q.tk)
                4'd0: kind = SMRT_K_ID;
                4'd1: str = name_of(code);
                4'd2, 4'd5, 4'd8: begin
                    kind = SMRT_K_NUM;
                    num = (q.tk == 4'd5) ? q.ch_tmp[q.ch[1:0]] : (q.tk == 4'd8) ? q.ch_raw[q.ch[1:0]] : num;
                end
                4'd3, 4'd9: str = unit_of(code);
                4'd4: str = "TEMP";
                4'd6: str = "DEG. C";
                4'd7: str = "RAW";
                // (R12) High alarm takes precedence over low
                4'd10: str = q.ch_st[q.ch[1:0]][`SMRT_CHST_HI] ? S_HI : "LOALM";
                4'd11: str = S_NOC;
                `SMRT_LAST_TK: kind = SMRT_K_CR;
                default: kind = SMRT_K_NONE;
            endcase
            if (q.tk != 4'd0 && q.tk < `SMRT_LAST_TK && !keep[q.tk - 4'd1]) begin
                kind = SMRT_K_NONE;
            end
        end
        // (R17) Field width includes the period
        case (kind)
            SMRT_K_ID, SMRT_K_CR: len = 4'd1;
            SMRT_K_STR: len = str_len(str);
            SMRT_K_NUM: len = (num[22:20] != 3'd0) ? 4'd6 : 4'd5;
            SMRT_K_DATE: len = 4'd10;
            SMRT_K_TIME: len = 4'd8;
            default: len = 4'd0;
        endcase
        case (kind)
            // (R8) Unit ID high, channel low
            SMRT_K_ID: chr = {q.ctrl[`SMRT_CTRL_UID], (q.ch == 3'd4) ? `SMRT_DATE_ID : {1'b0, q.ch}};
            // (R6) Single terminator
            SMRT_K_CR: chr = 8'h0D;
            SMRT_K_STR: chr = str[8*(len - 4'd1 - q.ci) +: 8];
            SMRT_K_NUM: chr = num_char(num, q.ci);
            SMRT_K_DATE: chr = dt_char(q.date, 4'd7, 8'h2D, q.ci);
            SMRT_K_TIME: chr = dt_char({8'h0, q.tod}, 4'd5, 8'h3A, q.ci);
            default: chr = 8'h20;
        endcase
    end

    // ==========================================================
    // Next state
    logic [7:0] tx_byte;
    logic [11:0] frame;
    logic [3:0] nbits;
    logic tick;
    logic [1:0] ev;
    logic [1:0] w1c;
    logic wr;
    logic [31:0] rd;
    logic hit;

    always_comb begin
        d = q;
        ev = 2'b00;
        w1c = 2'b00;
        tick = 1'b0;
        tx_byte = 8'h20;
        // (R15) Three-stage sense sync, taken when stages 2 and 3 agree
        for (int n = 0; n < 4; n++) begin
            d.s1[4*n +: 4] = {i_type_code_bit_weight8[n], i_type_code_bit_weight4[n],
                              i_type_code_bit_weight2[n], i_type_code_bit_weight1[n]};
        end
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.code = (q.code & (q.s2 ^ q.s3)) | (q.s3 & ~(q.s2 ^ q.s3));

        // (R4) Scan timer; a tick during a packet is reported, not queued
        if (!q.ctrl[`SMRT_CTRL_EN]) begin
            d.scan_cnt = 32'h0000_0000;
        end else if (q.scan_cnt + 32'h0000_0001 >= q.scan) begin
            d.scan_cnt = 32'h0000_0000;
            tick = 1'b1;
        end else begin
            d.scan_cnt = q.scan_cnt + 32'h0000_0001;
        end

        // (R5) 7-bit data drops bit 7, which ASCII never uses
        // (R18) Start low, data LSB first, parity, stop bits high
        frame = 12'hFFF;
        frame[0] = 1'b0;
        frame[8:1] = tx_byte;
        nbits = 4'd10;

        case (q.st)
            SMRT_IDLE: begin
                if (tick) begin
                    d.st = SMRT_CHAR;
                    d.ch = 3'd0;
                    d.tk = 4'd0;
                    d.ci = 4'd0;
                    d.sep = 1'b0;
                    d.spd = 1'b0;
                end
            end
            SMRT_CHAR: begin
                if (q.ci >= len) begin
                    d.ci = 4'd0;
                    d.spd = 1'b0;
                    d.tk = q.tk + 4'd1;
                    if (q.tk == `SMRT_LAST_TK) begin
                        d.tk = 4'd0;
                        d.sep = 1'b0;
                        d.ch = q.ch + 3'd1;
                        if (q.ch == 3'd4) begin
                            d.st = SMRT_IDLE;
                            ev[`SMRT_INT_DONE] = 1'b1;
                        end
                    end
                end else begin
                    // (R9) One space between fields
                    if (q.sep && !q.spd && q.ci == 4'd0 && kind != SMRT_K_CR) begin
                        tx_byte = 8'h20;
                        d.spd = 1'b1;
                    end else begin
                        tx_byte = chr;
                        d.ci = q.ci + 4'd1;
                        d.sep = (kind != SMRT_K_ID);
                    end
                    // (R3) Framing from control bits
                    frame[8:1] = tx_byte;
                    if (q.ctrl[`SMRT_CTRL_SEVEN]) begin
                        frame[8] = 1'b1;
                    end
                    if (q.ctrl[`SMRT_CTRL_PAR_EN]) begin
                        frame[q.ctrl[`SMRT_CTRL_SEVEN] ? 8 : 9] =
                            ^(q.ctrl[`SMRT_CTRL_SEVEN] ? {1'b0, tx_byte[6:0]} : tx_byte)
                            ^ q.ctrl[`SMRT_CTRL_PAR_ODD];
                    end
                    nbits = 4'd10 - {3'd0, q.ctrl[`SMRT_CTRL_SEVEN]} + {3'd0, q.ctrl[`SMRT_CTRL_PAR_EN]}
                            + {3'd0, q.ctrl[`SMRT_CTRL_TWO_STOP]};
                    d.sh = frame;
                    d.bit_cnt = nbits;
                    d.baud_cnt = 16'h0000;
                    d.st = SMRT_TX;
                end
            end
            SMRT_TX: begin
                // (R1) Paced by the baud counter alone, no flow control
                if (q.baud_cnt == 16'h0000) begin
                    if (q.bit_cnt == 4'd0) begin
                        d.st = SMRT_CHAR;
                    end else begin
                        d.tx = q.sh[0];
                        d.sh = {1'b1, q.sh[11:1]};
                        d.bit_cnt = q.bit_cnt - 4'd1;
                        d.baud_cnt = (q.baud == 16'h0000) ? 16'h0000 : q.baud - 16'h0001;
                    end
                end else begin
                    d.baud_cnt = q.baud_cnt - 16'h0001;
                end
            end
            default: d.st = SMRT_IDLE;
        endcase
        if (tick && q.st != SMRT_IDLE) begin
            ev[`SMRT_INT_OVR] = 1'b1;
        end

        // ==========================================================
        // APB slave: zero wait states, read data latched in setup
        hit = 1'b1;
        rd = 32'h0000_0000;
        if (i_paddr[7:6] == `SMRT_CH_REGION) begin
            case (i_paddr[3:2])
                2'd0: rd = {9'h0, q.ch_val[i_paddr[5:4]]};
                2'd1: rd = {9'h0, q.ch_tmp[i_paddr[5:4]]};
                2'd2: rd = {9'h0, q.ch_raw[i_paddr[5:4]]};
                default: rd = {28'h0, q.ch_st[i_paddr[5:4]]};
            endcase
        end else begin
            case (i_paddr)
                `SMRT_OFF_CTRL: rd = {20'h0, q.ctrl};
                `SMRT_OFF_BAUD: rd = {16'h0, q.baud};
                `SMRT_OFF_SCAN: rd = q.scan;
                `SMRT_OFF_DATE: rd = q.date;
                `SMRT_OFF_TIME: rd = {8'h0, q.tod};
                `SMRT_OFF_STAT: rd = {12'h0, q.code, 3'h0, q.st != SMRT_IDLE};
                `SMRT_OFF_INT: rd = {30'h0, q.int_st};
                `SMRT_OFF_MASK: rd = {30'h0, q.int_mask};
                default: hit = 1'b0;
            endcase
        end
        hit = hit && (i_paddr[1:0] == 2'b00);
        if (i_psel && !i_penable) begin
            d.prdata = (hit && !i_pwrite) ? rd : 32'h0000_0000;
            d.pslverr = !hit;
        end
        wr = i_psel && i_penable && i_pwrite && hit;
        if (wr) begin
            if (i_paddr[7:6] == `SMRT_CH_REGION) begin
                case (i_paddr[3:2])
                    2'd0: d.ch_val[i_paddr[5:4]] = i_pwdata[22:0];
                    2'd1: d.ch_tmp[i_paddr[5:4]] = i_pwdata[22:0];
                    2'd2: d.ch_raw[i_paddr[5:4]] = i_pwdata[22:0];
                    default: d.ch_st[i_paddr[5:4]] = i_pwdata[3:0];
                endcase
            end else begin
                case (i_paddr)
                    `SMRT_OFF_CTRL: d.ctrl = i_pwdata[11:0];
                    `SMRT_OFF_BAUD: d.baud = i_pwdata[15:0];
                    `SMRT_OFF_SCAN: d.scan = i_pwdata;
                    `SMRT_OFF_DATE: d.date = i_pwdata;
                    `SMRT_OFF_TIME: d.tod = i_pwdata[23:0];
                    `SMRT_OFF_INT: w1c = i_pwdata[1:0];
                    `SMRT_OFF_MASK: d.int_mask = i_pwdata[1:0];
                    default: ;
                endcase
            end
        end
        // New event beats a same-cycle clear
        d.int_st = (q.int_st & ~w1c) | ev;
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            q <= '0;
            q.st <= SMRT_IDLE;
            q.ctrl <= `SMRT_CTRL_RST;
            q.baud <= 16'(`SMRT_BAUD_RST);
            q.scan <= P_SCAN_RST;
            q.sh <= 12'hFFF;
            q.tx <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    assign o_pready = 1'b1;
    assign o_prdata = q.prdata;
    assign o_pslverr = q.pslverr && i_psel && i_penable;
    // (R2) Only the transmit wire is driven; receive is ignored
    assign o_tx = q.tx;
    // (R16) Range select from channel status
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            o_range_sel[i] = q.ch_st[i][`SMRT_CHST_RANGE];
        end
    end
    assign o_irq = |(q.int_st & q.int_mask);

endmodule // smrt_tx

/* File: smrt_regs.svh */
// Constants of the report sender
// Functional notes
// (R1) Transmit only; never waits for any handshake from the recorder.
// (R2) Link is three wires: transmit, receive (unused here) and ground.
// (R3) Baud, parity, data bits and stop bits set by software.
// (R4) One whole report packet per scan period.
// (R5) Every byte is printable ASCII or a carriage return. The ID byte is sent unchecked as raw unit ID and channel nibbles.
// (R6) Each message ends with exactly one carriage return.
// (R7) Last message of a packet is date and time stamp.
// (R8) Message starts with ID byte: unit ID high nibble, channel low.
// (R9) Each field name is followed by one space.
// (R10) Value has at most five digits, with a period at the point.
// (R11) Value is followed by a space and a units text.
// (R12) Channel message may carry alarm or uncalibrated marker.
// (R13) Uncalibrated channel sends only ID byte and uncalibrated marker.
// (R14) Field set and order depend on the parameter type.
// (R15) Four sense inputs per channel give a weighted 4-bit type code.
// (R16) One range-select output per channel toward the preamp.
// (R17) Field width counts name, data, units and decimal point.
// (R18) Characters framed: start, data LSB first, parity, stop; idle high.
`ifndef SMRT_REGS_SVH
`define SMRT_REGS_SVH

// ==========================================================
// Offsets
`define SMRT_OFF_CTRL 8'h00
`define SMRT_OFF_BAUD 8'h04
`define SMRT_OFF_SCAN 8'h08
`define SMRT_OFF_DATE 8'h0C
`define SMRT_OFF_TIME 8'h10
`define SMRT_OFF_STAT 8'h14
`define SMRT_OFF_INT 8'h18
`define SMRT_OFF_MASK 8'h1C
// Channel block: 0x40 + ch*0x10, words value/temp/raw/status
`define SMRT_CH_REGION 2'b01

// ==========================================================
// Control, channel status and interrupt fields
`define SMRT_CTRL_EN 0
`define SMRT_CTRL_UID 7:4
`define SMRT_CTRL_PAR_EN 8
`define SMRT_CTRL_PAR_ODD 9
`define SMRT_CTRL_SEVEN 10
`define SMRT_CTRL_TWO_STOP 11
`define SMRT_CHST_CAL 0
`define SMRT_CHST_HI 1
`define SMRT_CHST_LO 2
`define SMRT_CHST_RANGE 3
`define SMRT_INT_DONE 0
`define SMRT_INT_OVR 1

// ==========================================================
// Reset values and timing
`define SMRT_CTRL_RST 12'h0000
`define SMRT_CLK_HZ 250000000
`define SMRT_BAUD_RATE 9600
`define SMRT_BAUD_RST (`SMRT_CLK_HZ / `SMRT_BAUD_RATE)
`define SMRT_SCAN_MS 1000
`define SMRT_SCAN_RST (`SMRT_SCAN_MS * (`SMRT_CLK_HZ / 1000))
`define SMRT_DATE_ID 4'h8
`define SMRT_LAST_TK 4'd12

`endif

/* File: smrt_pkg.sv */
// Types of the serial measurement report sender
package smrt_pkg;

    typedef enum logic [1:0] {
        SMRT_IDLE = 2'b00,
        SMRT_CHAR = 2'b01,
        SMRT_TX = 2'b11
    } smrt_st_e;

    typedef enum logic [2:0] {
        SMRT_K_NONE,
        SMRT_K_ID,
        SMRT_K_STR,
        SMRT_K_NUM,
        SMRT_K_DATE,
        SMRT_K_TIME,
        SMRT_K_CR
    } smrt_kind_e;

    typedef struct packed {
        smrt_st_e st;
        logic [11:0] ctrl;
        logic [15:0] baud;
        logic [31:0] scan;
        logic [31:0] date;
        logic [23:0] tod;
        logic [3:0][22:0] ch_val;
        logic [3:0][22:0] ch_tmp;
        logic [3:0][22:0] ch_raw;
        logic [3:0][3:0] ch_st;
        logic [1:0] int_st;
        logic [1:0] int_mask;
        logic [15:0] s1;
        logic [15:0] s2;
        logic [15:0] s3;
        logic [15:0] code;
        logic [31:0] scan_cnt;
        logic [2:0] ch;
        logic [3:0] tk;
        logic [3:0] ci;
        logic sep;
        logic spd;
        logic [15:0] baud_cnt;
        logic [3:0] bit_cnt;
        logic [11:0] sh;
        logic tx;
        logic [31:0] prdata;
        logic pslverr;
    } smrt_state_s;

endpackage

/* File: smrt_tx_chk.sv */
// Port checker of the serial report sender
`timescale 1ns/1ps

module smrt_tx_chk (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic [31:0] o_prdata,
    input wire logic o_pslverr,
    input wire logic [3:0] i_type_code_bit_weight8,
    input wire logic [3:0] i_type_code_bit_weight4,
    input wire logic [3:0] i_type_code_bit_weight2,
    input wire logic [3:0] i_type_code_bit_weight1,
    input wire logic [3:0] o_range_sel,
    input wire logic o_tx,
    input wire logic o_irq
);
    logic wr;
    logic [15:0] baud_q, lo_q, cur, cur_q;
    logic [1:0] mask_q;
    logic rs_q;
    logic [3:0] sc_q;
    assign wr = i_psel && i_penable && i_pwrite;
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            cur[4*n+:4] = {i_type_code_bit_weight8[n], i_type_code_bit_weight4[n],
                i_type_code_bit_weight2[n], i_type_code_bit_weight1[n]};
        end
    end
    // ==========================================================
    // Shadows of the few registers the properties need, a line-low run counter and a sense stability count
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            {baud_q, lo_q, cur_q, mask_q, rs_q, sc_q} <= {16'h65b9, 16'h0000, 16'h0000, 2'b00, 1'b0, 4'h0};
        end else begin
            if (wr && i_paddr == 8'h04) baud_q <= i_pwdata[15:0];
            if (wr && i_paddr == 8'h1c) mask_q <= i_pwdata[1:0];
            if (wr && i_paddr == 8'h4c) rs_q <= i_pwdata[3];
            lo_q <= o_tx ? 16'h0000 : lo_q + 16'h0001;
            cur_q <= cur;
            sc_q <= (cur != cur_q) ? 4'h0 : sc_q + {3'h0, sc_q != 4'hf};
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    sequence start_edge; $fell(o_tx); endsequence
    sequence start_low; !o_tx [*3]; endsequence
    sequence status_write; wr && i_paddr == 8'h4c; endsequence
    ready_always_a: assert property (o_pready) else $error("pready low");
    bit_len_a: assert property ($rose(o_tx) |-> lo_q % baud_q == 16'h0000)
        else $error("low run not whole bits");
    start_hold_a: assert property (start_edge |-> start_low)
        else $error("start bit too short");
    reset_idle_a: assert property ($rose(i_rstn) |-> o_tx && !o_irq)
        else $error("line not idle after reset");
    range_sel_a: assert property (status_write |-> ##2 o_range_sel[0] == rs_q)
        else $error("range select not following status");
    sense_read_a: assert property (i_psel && !i_penable && i_paddr == 8'h14 && sc_q > 4'h8 |=> o_prdata[19:4] == cur)
        else $error("sensed codes wrong");
    err_misalign_a: assert property (i_psel && i_penable && i_paddr[1:0] != 2'b00 |-> o_pslverr && o_prdata == 0)
        else $error("misaligned access accepted");
    irq_mask_a: assert property (o_irq |-> mask_q != 2'b00 || $past(mask_q) != 2'b00)
        else $error("interrupt while masked");
endmodule // smrt_tx_chk

/* File: smrt_rx_model.sv */
// Recording device model: receives characters from the transmit line
`timescale 1ns/1ps

module smrt_rx_model (
    input wire logic i_core_clk,
    input wire logic i_line,
    input wire logic [15:0] i_baud,
    input wire logic i_seven,
    input wire logic i_par_en,
    input wire logic i_par_odd,
    input wire logic i_two_stop,
    output logic [9:0] o_rx_word,
    output logic o_rx_vld
);
    logic [7:0] dat;
    logic perr, ferr;
    initial begin
        o_rx_vld = 1'b0;
        o_rx_word = 10'h000;
        forever begin
            @(negedge i_line);
            repeat (i_baud / 2) @(posedge i_core_clk);
            ferr = i_line;
            dat = 8'h00;
            for (int k = 0; k < (i_seven ? 7 : 8); k++) begin
                repeat (i_baud) @(posedge i_core_clk);
                dat[k] = i_line;
            end
            perr = 1'b0;
            if (i_par_en) begin
                repeat (i_baud) @(posedge i_core_clk);
                perr = ^dat ^ i_par_odd ^ i_line;
            end
            for (int k = 0; k < (i_two_stop ? 2 : 1); k++) begin
                repeat (i_baud) @(posedge i_core_clk);
                ferr = ferr | !i_line;
            end
            o_rx_word <= {ferr, perr, dat};
            o_rx_vld <= 1'b1;
            @(posedge i_core_clk);
            o_rx_vld <= 1'b0;
        end
    end
endmodule // smrt_rx_model

/* File: smrt_tx_tb.sv */
// Self-checking bench of the serial report sender
`timescale 1ns/1ps

module smrt_tx_tb;
    logic i_core_clk, i_rstn, i_psel, i_penable, i_pwrite, i_rx, o_pready, o_pslverr, o_tx, o_irq;
    logic [7:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, seed, r;
    logic [3:0] i_type_code_bit_weight8, i_type_code_bit_weight4, i_type_code_bit_weight2;
    logic [3:0] i_type_code_bit_weight1, o_range_sel, uid;
    logic m_seven, m_par, m_odd, m_two, rx_vld;
    logic [9:0] rx_word;
    logic [15:0] codes;
    logic [22:0] v[4];
    logic [22:0] vq[$];
    logic [7:0] exp_ch[$];
    logic [31:0] exp_rd[$];
    logic [3:0] cfg[3] = '{4'h0, 4'h7, 4'h9};
    int n_mismatch = 0;
    int tests_run = 0;

    smrt_tx #(.P_SCAN_RST(32'h0000_07d0)) i_dut (.*);
    smrt_rx_model i_rec (.i_core_clk(i_core_clk), .i_line(o_tx), .i_baud(16'h0004), .i_seven(m_seven),
        .i_par_en(m_par), .i_par_odd(m_odd), .i_two_stop(m_two), .o_rx_word(rx_word), .o_rx_vld(rx_vld));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        do @(posedge i_core_clk); while (o_pready !== 1'b1);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic chk_irq(input logic e);
        #1 check({31'h0, o_irq}, {31'h0, e});
        @(posedge i_core_clk);
    endtask
    // Value slots marked by @ take the next queued value
    task automatic push_m(input logic [3:0] ch, input string s);
        logic [22:0] x;
        exp_ch.push_back({uid, ch});
        foreach (s[i]) begin
            if (s[i] == "@") begin
                x = vq.pop_front();
                for (int k = 0; k < 5; k++) begin
                    if (k == x[22:20] && k != 0) exp_ch.push_back(".");
                    exp_ch.push_back(8'h30 + x[19-4*k-:4]);
                end
            end else begin
                exp_ch.push_back(s[i]);
            end
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Clock, watchdog and result monitor
    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end
    initial begin
        repeat (60000) @(posedge i_core_clk);
        n_mismatch++;
        end_sim();
    end
    always @(posedge i_core_clk) begin
        // Receive line wiggles; the sender must ignore it
        i_rx <= ~i_rx;
        if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1) begin
            check(o_prdata, exp_rd.pop_front());
        end
        if (rx_vld) begin
            check({22'h0, rx_word}, exp_ch.size() ? {24'h0, exp_ch.pop_front()} : 32'hffff_ffff);
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        {i_rstn, i_psel, i_penable, i_pwrite, i_rx, m_seven, m_par, m_odd, m_two} = '0;
        {i_paddr, i_pwdata, i_type_code_bit_weight8, i_type_code_bit_weight4} = '0;
        {i_type_code_bit_weight2, i_type_code_bit_weight1} = '0;
        seed = 32'h0000_0015;
        repeat (6) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        r = xs();
        codes = {r[7:0], 8'h41};
        for (int n = 0; n < 4; n++) begin
            {i_type_code_bit_weight8[n], i_type_code_bit_weight4[n], i_type_code_bit_weight2[n],
                i_type_code_bit_weight1[n]} <= codes[4*n+:4];
        end
        rd(8'h00, 32'h0000_0000);
        rd(8'h04, 32'h0000_65b9);
        rd(8'h30, 32'h0000_0000);
        rd(8'h06, 32'h0000_0000);
        rd(8'h14, {12'h000, codes, 4'h0});
        $display("registers done");
        apb(1'b1, 8'h04, 32'h0000_0004);
        apb(1'b1, 8'h08, 32'h0000_2710);
        apb(1'b1, 8'h0c, 32'h0912_1994);
        apb(1'b1, 8'h10, 32'h0017_0148);
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 5; k++) v[i][4*k+:4] = 4'(xs() % 10);
            v[i][22:20] = 3'(xs() % 5);
            apb(1'b1, (i < 3) ? 8'(8'h40 + 4 * i) : 8'h50, {9'h000, v[i]});
        end
        apb(1'b1, 8'h4c, 32'h0000_0009);
        apb(1'b1, 8'h5c, 32'h0000_0007);
        for (int f = 0; f < 3; f++) begin
            {m_two, m_seven, m_odd, m_par} = cfg[f];
            // Seven data bits carry only three bits of unit ID
            uid = 4'(xs()) & {~m_seven, 3'h7};
            vq = '{v[0], v[1], v[2], v[3]};
            push_m(4'h0, string'({"CO", "ND @ uS TEMP @ DEG. C RAW @ uS\015"}));
            push_m(4'h1, string'({"ORP @ mV HI", "ALM\015"}));
            push_m(4'h2, string'({"NO", "CAL\015"}));
            push_m(4'h3, string'({"NO", "CAL\015"}));
            push_m(4'h8, "DATE 09-12-1994 TIME 17:01:48\015");
            apb(1'b1, 8'h1c, 32'h0000_0000);
            apb(1'b1, 8'h00, {20'h0_0000, cfg[f], uid, 4'h1});
            for (int t = 0; t < 20000 && exp_ch.size() > 0; t++) @(posedge i_core_clk);
            apb(1'b1, 8'h00, {20'h0_0000, cfg[f], uid, 4'h0});
            chk_irq(1'b0);
            rd(8'h18, 32'h0000_0001);
            apb(1'b1, 8'h1c, 32'h0000_0001);
            chk_irq(1'b1);
            apb(1'b1, 8'h18, 32'h0000_0001);
            chk_irq(1'b0);
            rd(8'h18, 32'h0000_0000);
            $display("framing %0d done", f);
        end
        repeat (7000) @(posedge i_core_clk);
        check(exp_ch.size(), 32'h0000_0000);
        end_sim();
    end
endmodule // smrt_tx_tb

bind smrt_tx smrt_tx_chk i_chk (.*);
